// ### logic/uart_flow_defines.vh
// Register offsets, field positions and reset values for the flow-control block
`ifndef UART_FLOW_DEFINES_VH
`define UART_FLOW_DEFINES_VH
`define ADDR_DMA_CTRL      8'h48
`define ADDR_FLOW_CTRL     8'h50
`define ADDR_RESUME1       8'h54
`define ADDR_RESUME2       8'h58
`define ADDR_PAUSE1        8'h5C
`define ADDR_PAUSE2        8'h60
`define ADDR_IRQ_RAW       8'h64
`define ADDR_IRQ_MASK      8'h68
`define ADDR_IRQ_MASKED    8'h6C
`define ADDR_FLOW_STATUS   8'h70
`define DMA_RX_EN_BIT      0
`define DMA_TX_EN_BIT      1
`define DMA_ERR_STOP_BIT   3
`define FLOW_EN_BIT        0
`define FLOW_RX_MODE_LO    1
`define FLOW_TX_MODE_LO    3
`define FLOW_ANY_BIT       5
`define FLOW_SPECIAL_BIT   6
`define IRQ_FRAMING_BIT    7
`define IRQ_PARITY_BIT     8
`define IRQ_BREAK_BIT      9
`define IRQ_OVERRUN_BIT    10
`define IRQ_PAUSE_BIT      11
`define IRQ_LO             7
`define IRQ_HI             11
`define MODE_OFF           2'h0
`define MODE_FIRST         2'h1
`define MODE_SECOND        2'h2
`define MODE_BOTH          2'h3
`define RESET_ZERO         32'h00000000
`endif

// ### logic/char_match.v
// Compares a received character against a selected resume/pause pair set
`timescale 1ns/1ps
module char_match (
  input  wire [1:0] mode,
  input  wire [7:0] char_in,
  input  wire [7:0] first_val,
  input  wire [7:0] second_val,
  output wire       hit
);
  // Mode selects the first, second or both pairs
  assign hit = (mode[0] && (char_in == first_val)) || (mode[1] && (char_in == second_val));
endmodule

// ### logic/uart_flow_control_dma_ctrl.v
// UART flow-control and DMA-request control with Avalon-MM registers
//
// Contract
// - Rx DMA requests need rx enable bit
// - Tx DMA requests need tx enable bit
// - Stop-on-error blocks rx DMA on errors enabled in the irq mask
// - Flow control only when enable set
// - Rx mode selects first/second/both pairs
// - Tx mode selects first/second/both pairs
// - Resume-on-any accepts any character except a selected pause char
// - Otherwise resume must match programmed chars
// - Special detection only when bit set
// - First resume char register, reset zero
// - Second resume char register, reset zero
// - First pause char register, reset zero
// - Second pause char register, reset zero
// - Raw/masked error status for four errors
// - Pause detect interrupt, write-one clear
`timescale 1ns/1ps
`include "uart_flow_defines.vh"
module uart_flow_control_dma_ctrl (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output reg         response_error,
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char,
  input  wire        framing_error,
  input  wire        parity_error,
  input  wire        break_error,
  input  wire        overrun_error,
  input  wire        rx_data_ready,
  input  wire        tx_data_ready,
  input  wire        rx_room,
  input  wire        tx_char_done,
  input  wire        tx_ctrl_ready,
  output reg         rx_dma_req,
  output reg         tx_dma_req,
  output wire        tx_hold,
  output reg         tx_ctrl_valid,
  output reg  [7:0]  tx_ctrl_char,
  output reg         special_char_seen,
  output wire        irq
);
  reg  [31:0] dma_ctrl;
  reg  [31:0] flow_ctrl;
  reg  [7:0]  resume_char_first;
  reg  [7:0]  resume_char_second;
  reg  [7:0]  pause_char_first;
  reg  [7:0]  pause_char_second;
  reg  [12:0] irq_raw;
  reg  [12:0] irq_mask;
  reg         tx_paused;
  reg         pause_owed;
  reg         rx_stopped;
  reg         ack;
  reg  [31:0] next_readdata;
  reg         next_error;
  reg  [12:0] next_irq_raw;
  wire [31:0] wmask;
  wire        soft_flow_enable;
  wire [1:0]  rx_flow_mode;
  wire [1:0]  tx_flow_mode;
  wire        resume_on_any_char;
  wire        special_char_detect;
  wire        rx_flow_on;
  wire        tx_flow_on;
  wire        pause_hit;
  wire        resume_hit;
  wire        resume_valid;
  wire        special_hit_rx;
  wire        special_hit_tx;
  wire        rx_pause_hit;
  wire        rx_resume_hit;
  wire        error_irq;
  wire        wr_ok;
  wire        mapped;
  wire [12:0] irq_masked;
  wire [7:0]  sel_pause;
  wire [7:0]  sel_resume;
  genvar      lane;

  assign soft_flow_enable    = flow_ctrl[`FLOW_EN_BIT];
  assign rx_flow_mode        = flow_ctrl[`FLOW_RX_MODE_LO+1:`FLOW_RX_MODE_LO];
  assign tx_flow_mode        = flow_ctrl[`FLOW_TX_MODE_LO+1:`FLOW_TX_MODE_LO];
  assign resume_on_any_char  = flow_ctrl[`FLOW_ANY_BIT];
  assign special_char_detect = flow_ctrl[`FLOW_SPECIAL_BIT];

  // Single-cycle wait: every access is answered one edge after it appears
  assign waitrequest = (read || write) && !ack;
  assign wr_ok       = write && !waitrequest;
  assign mapped      = (address == `ADDR_DMA_CTRL) || (address == `ADDR_FLOW_CTRL) ||
                       (address == `ADDR_RESUME1) || (address == `ADDR_RESUME2) ||
                       (address == `ADDR_PAUSE1) || (address == `ADDR_PAUSE2) ||
                       (address == `ADDR_IRQ_RAW) || (address == `ADDR_IRQ_MASK) ||
                       (address == `ADDR_IRQ_MASKED) || (address == `ADDR_FLOW_STATUS);

  // One write-mask byte per bus lane
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{byteenable[lane]}};
    end
  endgenerate

  assign rx_flow_on = soft_flow_enable && (rx_flow_mode != `MODE_OFF);
  assign tx_flow_on = soft_flow_enable && (tx_flow_mode != `MODE_OFF);

  char_match u_pause_match (
    .mode       (tx_flow_mode),
    .char_in    (rx_char),
    .first_val  (pause_char_first),
    .second_val (pause_char_second),
    .hit        (pause_hit)
  );

  char_match u_resume_match (
    .mode       (tx_flow_mode),
    .char_in    (rx_char),
    .first_val  (resume_char_first),
    .second_val (resume_char_second),
    .hit        (resume_hit)
  );

  char_match u_rx_pause_match (
    .mode       (rx_flow_mode),
    .char_in    (rx_char),
    .first_val  (pause_char_first),
    .second_val (pause_char_second),
    .hit        (rx_pause_hit)
  );

  char_match u_rx_resume_match (
    .mode       (rx_flow_mode),
    .char_in    (rx_char),
    .first_val  (resume_char_first),
    .second_val (resume_char_second),
    .hit        (rx_resume_hit)
  );

  assign resume_valid = resume_on_any_char || resume_hit;

  assign special_hit_rx = special_char_detect && rx_char_valid &&
                          (rx_pause_hit || rx_resume_hit);
  assign special_hit_tx = special_char_detect && rx_char_valid &&
                          (pause_hit || resume_hit);

  assign irq_masked = irq_raw & irq_mask;
  // Masked errors only, so software can let DMA run past an ignored error
  assign error_irq  = |irq_masked[`IRQ_OVERRUN_BIT:`IRQ_FRAMING_BIT];
  assign irq        = |irq_masked;
  assign tx_hold    = tx_paused;

  // Both-pairs mode sends the first pair; the second pair is only matched
  // Receive mode pair select
  assign sel_pause  = (rx_flow_mode == `MODE_SECOND) ? pause_char_second : pause_char_first;
  assign sel_resume = (rx_flow_mode == `MODE_SECOND) ? resume_char_second : resume_char_first;

  always @* begin
    next_irq_raw = irq_raw;
    if (wr_ok && (address == `ADDR_IRQ_RAW)) begin
      next_irq_raw = irq_raw & ~writedata[12:0];
    end
    // Set wins over a clear in the same cycle
    if (framing_error) begin
      next_irq_raw[`IRQ_FRAMING_BIT] = 1'b1;
    end
    if (parity_error) begin
      next_irq_raw[`IRQ_PARITY_BIT] = 1'b1;
    end
    if (break_error) begin
      next_irq_raw[`IRQ_BREAK_BIT] = 1'b1;
    end
    if (overrun_error) begin
      next_irq_raw[`IRQ_OVERRUN_BIT] = 1'b1;
    end
    if (tx_flow_on && rx_char_valid && pause_hit) begin
      next_irq_raw[`IRQ_PAUSE_BIT] = 1'b1;
    end
    next_irq_raw[`IRQ_LO-1:0] = 7'h00;
    next_irq_raw[12]          = 1'b0;
  end

  always @* begin
    next_readdata = `RESET_ZERO;
    next_error    = 1'b0;
    case (address)
      `ADDR_DMA_CTRL:    next_readdata = dma_ctrl;
      `ADDR_FLOW_CTRL:   next_readdata = flow_ctrl;
      `ADDR_RESUME1:     next_readdata = {24'h000000, resume_char_first};
      `ADDR_RESUME2:     next_readdata = {24'h000000, resume_char_second};
      `ADDR_PAUSE1:      next_readdata = {24'h000000, pause_char_first};
      `ADDR_PAUSE2:      next_readdata = {24'h000000, pause_char_second};
      `ADDR_IRQ_RAW:     next_readdata = {19'h0000, irq_raw};
      `ADDR_IRQ_MASK:    next_readdata = {19'h0000, irq_mask};
      `ADDR_IRQ_MASKED:  next_readdata = {19'h0000, irq_masked};
      `ADDR_FLOW_STATUS: next_readdata = {29'h0000000, rx_stopped, pause_owed, tx_paused};
      default: begin
        next_readdata = `RESET_ZERO;
        next_error    = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack            <= 1'b0;
      readdata       <= `RESET_ZERO;
      response_error <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
      if (read && !ack) begin
        readdata       <= next_readdata;
        response_error <= next_error;
      end else if (write && !ack) begin
        response_error <= !mapped;
      end
    end
  end

  // Register writes; reserved bits are kept zero in hardware
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma_ctrl           <= `RESET_ZERO;
      flow_ctrl          <= `RESET_ZERO;
      resume_char_first  <= 8'h00;
      resume_char_second <= 8'h00;
      pause_char_first   <= 8'h00;
      pause_char_second  <= 8'h00;
      irq_mask           <= 13'h0000;
      irq_raw            <= 13'h0000;
    end else begin
      irq_raw <= next_irq_raw;
      if (wr_ok) begin
        case (address)
          `ADDR_DMA_CTRL: begin
            dma_ctrl <= (dma_ctrl & ~wmask) | (writedata & wmask & 32'h0000000B);
          end
          `ADDR_FLOW_CTRL: begin
            flow_ctrl <= (flow_ctrl & ~wmask) | (writedata & wmask & 32'h0000007F);
          end
          `ADDR_RESUME1: begin
            if (byteenable[0]) begin
              resume_char_first <= writedata[7:0];
            end
          end
          `ADDR_RESUME2: begin
            if (byteenable[0]) begin
              resume_char_second <= writedata[7:0];
            end
          end
          `ADDR_PAUSE1: begin
            if (byteenable[0]) begin
              pause_char_first <= writedata[7:0];
            end
          end
          `ADDR_PAUSE2: begin
            if (byteenable[0]) begin
              pause_char_second <= writedata[7:0];
            end
          end
          `ADDR_IRQ_MASK: begin
            irq_mask <= writedata[12:0] & 13'h0F80;
          end
          default: begin
            irq_mask <= irq_mask;
          end
        endcase
      end
    end
  end

  // DMA requests and flow state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_dma_req        <= 1'b0;
      tx_dma_req        <= 1'b0;
      tx_paused         <= 1'b0;
      pause_owed        <= 1'b0;
      rx_stopped        <= 1'b0;
      tx_ctrl_valid     <= 1'b0;
      tx_ctrl_char      <= 8'h00;
      special_char_seen <= 1'b0;
    end else begin
      rx_dma_req <= dma_ctrl[`DMA_RX_EN_BIT] && rx_data_ready &&
                    !(dma_ctrl[`DMA_ERR_STOP_BIT] && error_irq);
      tx_dma_req <= dma_ctrl[`DMA_TX_EN_BIT] && tx_data_ready && !tx_paused;
      special_char_seen <= special_hit_rx || special_hit_tx;
      // Pause blocks the next character at once; one already going out still finishes
      // Hold transmit until resume
      if (!tx_flow_on) begin
        tx_paused  <= 1'b0;
        pause_owed <= 1'b0;
      end else if (rx_char_valid && pause_hit) begin
        tx_paused  <= 1'b1;
        pause_owed <= !tx_char_done;
      end else if (rx_char_valid && resume_valid) begin
        tx_paused  <= 1'b0;
        pause_owed <= 1'b0;
      end else if (tx_char_done) begin
        pause_owed <= 1'b0;
      end
      if (tx_ctrl_valid) begin
        if (tx_ctrl_ready) begin
          tx_ctrl_valid <= 1'b0;
        end
      end else if (rx_flow_on && !rx_room && !rx_stopped) begin
        tx_ctrl_valid <= 1'b1;
        tx_ctrl_char  <= sel_pause;
        rx_stopped    <= 1'b1;
      end else if (rx_stopped && (rx_room || !rx_flow_on)) begin
        tx_ctrl_valid <= rx_flow_on;
        tx_ctrl_char  <= sel_resume;
        rx_stopped    <= 1'b0;
      end
    end
  end
endmodule

// ### tb/uart_flow_asserts.sv
// Port assertions for the flow-control and DMA-request block
`timescale 1ns/1ps
module uart_flow_checker (
  input wire        clk_sys,
  input wire        rst_n,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire        waitrequest,
  input wire        framing_error,
  input wire        parity_error,
  input wire        break_error,
  input wire        overrun_error,
  input wire        rx_char_valid,
  input wire        rx_data_ready,
  input wire        tx_data_ready,
  input wire        tx_ctrl_ready,
  input wire        rx_dma_req,
  input wire        tx_dma_req,
  input wire        tx_hold,
  input wire        tx_ctrl_valid,
  input wire [7:0]  tx_ctrl_char,
  input wire        special_char_seen,
  input wire        irq
);
  reg  [3:0] dma;
  reg  [6:0] flow;
  reg  [4:0] mask;
  reg  [3:0] err;
  wire       taken = write && !waitrequest;
  wire       tx_on = flow[0] && (flow[4:3] != 2'h0);
  wire [3:0] ev    = {overrun_error, break_error, parity_error, framing_error};
  wire [3:0] clr   = (taken && address == 8'h64) ? writedata[10:7] : 4'h0;
  // Shadow of the programmed state, updated at the accepting edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma <= 4'h0;
      flow <= 7'h00;
      mask <= 5'h00;
      err <= 4'h0;
    end else begin
      if (taken && address == 8'h48) dma <= writedata[3:0];
      if (taken && address == 8'h50) flow <= writedata[6:0];
      if (taken && address == 8'h68) mask <= writedata[11:7];
      // Set wins over a same-cycle clear
      err <= ev | (err & ~clr);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
  AST_RX_DMA_EN: assert property (rx_dma_req |-> $past(dma[0] && rx_data_ready))
    else $error("rx request while disabled");
  AST_TX_DMA_EN: assert property (tx_dma_req |-> $past(dma[1] && tx_data_ready))
    else $error("tx request while disabled");
  AST_ERR_STOP: assert property (rx_dma_req |-> !$past(dma[3] && |(err & mask[3:0])))
    else $error("rx request during error");
  AST_IRQ_MASK: assert property (mask == 5'h00 |-> !irq)
    else $error("irq with all masked");
  AST_HOLD_OFF: assert property (!tx_on && $past(!tx_on) |-> !tx_hold)
    else $error("hold without tx flow");
  AST_CTRL_KEEP: assert property (tx_ctrl_valid && !tx_ctrl_ready |=>
    tx_ctrl_valid && $stable(tx_ctrl_char)) else $error("control char dropped");
  AST_SPECIAL: assert property (special_char_seen |-> $past(flow[6] && rx_char_valid))
    else $error("special without detect");
  AST_CTRL_RX: assert property ($rose(tx_ctrl_valid) |-> $past(flow[0] && |flow[2:1]))
    else $error("control char without rx flow");
endmodule
bind uart_flow_control_dma_ctrl uart_flow_checker chk (.clk_sys, .rst_n, .address, .read,
  .write, .writedata, .waitrequest, .framing_error, .parity_error, .break_error,
  .overrun_error, .rx_char_valid, .rx_data_ready, .tx_data_ready, .tx_ctrl_ready,
  .rx_dma_req, .tx_dma_req, .tx_hold, .tx_ctrl_valid, .tx_ctrl_char, .special_char_seen,
  .irq);

// ### tb/serial_partner.sv
// Remote serial device: sends characters, accepts control characters
`timescale 1ns/1ps
module serial_partner (
  input  wire       clk_sys,
  input  wire       tx_ctrl_valid,
  input  wire [7:0] tx_ctrl_char,
  output reg        rx_char_valid = 1'b0,
  output reg  [7:0] rx_char = 8'h00,
  output reg        tx_ctrl_ready = 1'b0,
  output reg        tx_char_done = 1'b0
);
  reg [7:0] got = 8'h00;
  reg       slow = 1'b1;
  reg [1:0] cnt = 2'h0;
  // Line shows the inverse once the character is gone
  task send(input [7:0] c);
    begin
      @(posedge clk_sys);
      rx_char_valid <= 1'b1;
      rx_char <= c;
      @(posedge clk_sys);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
    end
  endtask
  // Slow mode accepts one control character in four cycles
  always @(posedge clk_sys) begin
    cnt <= cnt + 2'h1;
    tx_ctrl_ready <= !slow || cnt == 2'h3;
    tx_char_done <= tx_ctrl_valid && tx_ctrl_ready;
    if (tx_ctrl_valid && tx_ctrl_ready) got <= tx_ctrl_char;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the flow-control and DMA-request block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  address = 8'h00;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg  [31:0] writedata = 32'h0;
  reg  [3:0]  errs = 4'h0;
  reg         rx_data_ready = 1'b0;
  reg         tx_data_ready = 1'b0;
  reg         rx_room = 1'b1;
  integer     spc = 0;
  reg  [31:0] rd;
  integer     bad_count = 0;
  integer     checked = 0;
  integer     i;
  wire [31:0] readdata;
  wire [7:0]  rx_char, tx_ctrl_char;
  wire        waitrequest, response_error, rx_char_valid, tx_ctrl_ready, tx_char_done;
  wire        rx_dma_req, tx_dma_req, tx_hold, tx_ctrl_valid, special_char_seen, irq;
  logic [7:0]  ra [8] = '{8'h54, 8'h58, 8'h5C, 8'h60, 8'h48, 8'h50, 8'h68, 8'h80};
  logic [31:0] rv [8] = '{32'hA5, 32'h5A, 32'h13, 32'h17, 32'hB, 32'h7F, 32'hF80, 32'hFF};
  logic [31:0] re [8] = '{32'hA5, 32'h5A, 32'h13, 32'h17, 32'hB, 32'h7F, 32'hF80, 32'h0};
  logic [7:0]  fv [10] = '{8'h49, 8'h49, 8'h49, 8'h29, 8'h29, 8'h19, 8'h19, 8'h11, 8'h11, 8'h10};
  logic [7:0]  fc [10] = '{8'h13, 8'h41, 8'h11, 8'h13, 8'h41, 8'h17, 8'h11, 8'h13, 8'h17, 8'h41};
  logic        fh [10] = '{1, 1, 0, 1, 0, 1, 0, 0, 1, 0};
  uart_flow_control_dma_ctrl dut (.clk_sys, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .response_error, .rx_char_valid, .rx_char,
    .framing_error(errs[0]), .parity_error(errs[1]), .break_error(errs[2]),
    .overrun_error(errs[3]), .rx_data_ready, .tx_data_ready, .rx_room, .tx_char_done,
    .tx_ctrl_ready, .rx_dma_req, .tx_dma_req, .tx_hold, .tx_ctrl_valid, .tx_ctrl_char,
    .special_char_seen, .irq);
  serial_partner p (.clk_sys, .tx_ctrl_valid, .tx_ctrl_char, .rx_char_valid, .rx_char,
    .tx_ctrl_ready, .tx_char_done);
  initial forever #10 clk_sys = ~clk_sys;
  // Counts detection pulses so no second process has to clear a flag
  always @(posedge clk_sys) if (special_char_seen === 1'b1) spc <= spc + 1;
  // Request held until the edge that sees waitrequest low
  task acc(input r, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      address <= a;
      read <= r;
      write <= !r;
      writedata <= d;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      acc(0, ra[i], rv[i]);
      acc(1, ra[i], 32'h0);
      settle(0);
      `CHK("readback", re[i], rd)
      `CHK("bus error", ra[i] == 8'h80, response_error)
    end
    $display("register rows done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      acc(1, ra[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    $display("reset test done");
    rx_data_ready <= 1'b1;
    tx_data_ready <= 1'b1;
    settle(3);
    `CHK("rx req", 1'b0, rx_dma_req)
    `CHK("tx req", 1'b0, tx_dma_req)
    acc(0, 8'h68, 32'hF80);
    for (i = 0; i < 8; i++) begin
      acc(0, 8'h48, (i < 4) ? 32'hB : 32'h3);
      @(posedge clk_sys);
      errs <= 4'h1 << (i % 4);
      @(posedge clk_sys);
      errs <= 4'h0;
      settle(2);
      `CHK("irq", 1'b1, irq)
      `CHK("rx req err", i >= 4, rx_dma_req)
      `CHK("tx req", 1'b1, tx_dma_req)
      acc(1, 8'h64, 32'h0);
      `CHK("raw err", 32'h80 << (i % 4), rd & 32'h780)
      acc(0, 8'h64, 32'h80 << (i % 4));
      settle(2);
      `CHK("rx req clr", 1'b1, rx_dma_req)
    end
    $display("dma test done");
    acc(0, 8'h5C, 32'h13);
    acc(0, 8'h54, 32'h11);
    acc(0, 8'h60, 32'h17);
    acc(0, 8'h58, 32'h12);
    for (i = 0; i < 10; i++) begin
      acc(0, 8'h50, {24'h0, fv[i]});
      p.send(fc[i]);
      settle(2);
      `CHK("tx hold", fh[i], tx_hold)
      if (i == 0) `CHK("pause irq", 1'b1, irq)
      // Rows 0 and 2 carry a matching character with detection on
      if (i == 2) `CHK("special", 2, spc)
    end
    `CHK("special off", 2, spc)
    acc(1, 8'h64, 32'h0);
    `CHK("pause raw", 32'h800, rd & 32'h800)
    acc(0, 8'h64, 32'h800);
    settle(1);
    `CHK("pause clr", 1'b0, irq)
    $display("tx flow test done");
    for (i = 1; i < 3; i++) begin
      p.slow = (i == 1);
      acc(0, 8'h50, (i << 1) | 1);
      rx_room <= 1'b0;
      settle(12);
      `CHK("pause sent", (i == 1) ? 8'h13 : 8'h17, p.got)
      @(posedge clk_sys);
      rx_room <= 1'b1;
      settle(12);
      `CHK("resume sent", (i == 1) ? 8'h11 : 8'h12, p.got)
    end
    $display("rx flow test done");
    summarize;
  end
endmodule
